// file: rtl/fwsp_ctrl.sv
// Host controller driving a parallel flash and polling its write status
//
// The register addresses and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ns
`include "fwsp_defs.svh"

// Contract
// [R1] Device sets timeout flag after pulse limit
// [R2] During timeout only polling and toggle work
// [R3] Host issues reset command after timeout
// [R4] Unerased program never raises timeout flag
// [R5] Program status: inverted data, toggling, busy
// [R6] Erase status: zero, both toggle, window high
// [R7] Timeout keeps toggling and busy low
// [R8] Host reads status at valid address
// [R9] Window flag low until sector timer ends
// [R10] Status valid right after erase command
// [R11] Window high: further commands ignored
// [R12] Window low: more sector commands accepted
// [R13] Host checks window before and after command; the code reads it before the write but sets reject from the read after it only
// [R14] Power-up enters array read mode
// [R15] Array changes only after full sequence
// [R16] Strobe glitches under 5ns ignored
// [R17] Writes inhibited unless strobes allow it
// [R18] Host writes with chip-select, write low, output high
// [R19] Polling bit complement until programmed
// [R20] Toggle bit inverts each read while busy
// [R21] Reset command clears timeout, returns ready
module fwsp_ctrl
(
   input  wire logic                    I_REF_CLK,
   input  wire logic                    I_RESETN,
   input  wire logic                    I_CE,
   input  wire logic                    I_WB_CYC,
   input  wire logic                    I_WB_STB,
   input  wire logic                    I_WB_WE,
   input  wire logic [`FWSP_WB_AW-1:0]  I_WB_ADR,
   input  wire logic [31:0]             I_WB_DAT,
   input  wire logic [3:0]              I_WB_SEL,
   output logic      [31:0]             O_WB_DAT,
   output logic                         O_WB_ACK,
   output fwsp_pkg::fwsp_pins_t         O_FLASH,
   input  wire logic [`FWSP_DW-1:0]     I_FL_DQ,
   input  wire logic                    I_READY_BUSY_N
);
   import fwsp_pkg::*;
   // ==========================================================================
   // Helpers
   function automatic logic fwsp_hit(input logic [`FWSP_WB_AW-1:0] a,
                                     input logic [`FWSP_WB_AW-1:0] off);
      fwsp_hit = (a == off);
   endfunction : fwsp_hit

   function automatic logic fwsp_is_wr(input logic [2:0] op, input logic [1:0] step);
      fwsp_is_wr = (op == `FWSP_OP_WRITE) || (op == `FWSP_OP_RESET) ||
                   ((op == `FWSP_OP_SECT) && (step == 2'h1));
   endfunction : fwsp_is_wr
   function automatic fwsp_pins_t fwsp_launch(input logic wr,
                                              input logic [`FWSP_AW-1:0] a,
                                              input logic [`FWSP_DW-1:0] d);
      fwsp_launch.ce_n  = 1'b0;
      fwsp_launch.we_n  = 1'b1;
      fwsp_launch.oe_n  = wr;
      fwsp_launch.addr  = a;
      fwsp_launch.dq    = d;
      fwsp_launch.dq_oe = wr;
   endfunction : fwsp_launch
   // ==========================================================================
   // Bus slave state
   logic                 ack_r,   ack_nxt;
   logic [31:0]          dat_r,   dat_nxt;
   logic [`FWSP_AW-1:0]  addr_r,  addr_nxt;
   logic [`FWSP_DW-1:0]  wdata_r, wdata_nxt;
   logic                 go_r,    go_nxt;
   logic [2:0]           gop_r,   gop_nxt;
   // Engine state
   fwsp_state_t          st_r,    st_nxt;
   fwsp_pins_t           pins_r,  pins_nxt;
   logic [2:0]           cnt_r,   cnt_nxt;
   logic [1:0]           step_r,  step_nxt;
   logic [2:0]           op_r,    op_nxt;
   logic [`FWSP_DW-1:0]  rdata_r, rdata_nxt;
   logic                 tog_r,   tog_nxt;
   fwsp_stat_t           stat_r,  stat_nxt;

   // ==========================================================================
   // Wishbone register access
   always_comb
   begin
      ack_nxt   = I_WB_CYC & I_WB_STB & ~ack_r;
      dat_nxt   = dat_r;
      addr_nxt  = addr_r;
      wdata_nxt = wdata_r;
      go_nxt    = 1'b0;
      gop_nxt   = gop_r;
      if (ack_nxt)
      begin
         dat_nxt = 32'h0;
         if (I_WB_WE)
         begin
            if (fwsp_hit(I_WB_ADR, `FWSP_REG_CMD) && I_WB_SEL[0] && !stat_r.busy && !go_r)
            begin
               go_nxt  = 1'b1;
               gop_nxt = I_WB_DAT[2:0];
            end
            if (fwsp_hit(I_WB_ADR, `FWSP_REG_ADDR))
            begin
               if (I_WB_SEL[0])
                  addr_nxt[7:0] = I_WB_DAT[7:0];
               if (I_WB_SEL[1])
                  addr_nxt[15:8] = I_WB_DAT[15:8];
               if (I_WB_SEL[2])
                  addr_nxt[`FWSP_AW-1:16] = I_WB_DAT[`FWSP_AW-1:16];
            end
            if (fwsp_hit(I_WB_ADR, `FWSP_REG_WDATA))
            begin
               if (I_WB_SEL[0])
                  wdata_nxt[7:0] = I_WB_DAT[7:0];
               if (I_WB_SEL[1])
                  wdata_nxt[15:8] = I_WB_DAT[15:8];
            end
         end
         else if (fwsp_hit(I_WB_ADR, `FWSP_REG_CMD))
            dat_nxt = {29'h0, op_r};
         else if (fwsp_hit(I_WB_ADR, `FWSP_REG_ADDR))
            dat_nxt = {{(32-`FWSP_AW){1'b0}}, addr_r};
         else if (fwsp_hit(I_WB_ADR, `FWSP_REG_WDATA))
            dat_nxt = {16'h0, wdata_r};
         else if (fwsp_hit(I_WB_ADR, `FWSP_REG_RDATA))
            dat_nxt = {16'h0, rdata_r};
         else if (fwsp_hit(I_WB_ADR, `FWSP_REG_STATUS))
            dat_nxt = {27'h0, stat_r};
      end
   end

   always_ff @(posedge I_REF_CLK)
   begin
      if (!I_RESETN)
      begin
         ack_r   <= 1'b0;
         dat_r   <= 32'h0;
         addr_r  <= '0;
         wdata_r <= '0;
         go_r    <= 1'b0;
         gop_r   <= 3'h0;
      end
      else if (I_CE)
      begin
         ack_r   <= ack_nxt;
         dat_r   <= dat_nxt;
         addr_r  <= addr_nxt;
         wdata_r <= wdata_nxt;
         go_r    <= go_nxt;
         gop_r   <= gop_nxt;
      end
   end

   // ==========================================================================
   // Flash cycle engine
   always_comb
   begin
      st_nxt       = st_r;
      pins_nxt     = pins_r;
      cnt_nxt      = cnt_r + 3'h1;
      step_nxt     = step_r;
      op_nxt       = op_r;
      rdata_nxt    = rdata_r;
      tog_nxt      = tog_r;
      stat_nxt     = stat_r;
      stat_nxt.ready = I_READY_BUSY_N;
      case (st_r)
         FWSP_S_IDLE:
         begin
            cnt_nxt = 3'h0;
            if (go_r)
            begin
               op_nxt        = gop_r;
               step_nxt      = 2'h0;
               stat_nxt.busy = 1'b1;
               stat_nxt.done = 1'b0;
               if (gop_r == `FWSP_OP_SECT)
                  stat_nxt.reject = 1'b0;
               // Reset command uses fixed data
               pins_nxt = fwsp_launch(fwsp_is_wr(gop_r, 2'h0), addr_r,   // R3 R8
                             (gop_r == `FWSP_OP_RESET) ? `FWSP_FL_RESET_CMD : wdata_r);
               st_nxt   = fwsp_is_wr(gop_r, 2'h0) ? FWSP_S_WSET : FWSP_S_RLOW;
            end
         end
         FWSP_S_WSET:
         begin
            pins_nxt.we_n = 1'b0;                                   // R18 R17
            cnt_nxt       = 3'h0;
            st_nxt        = FWSP_S_WLOW;
         end
         FWSP_S_WLOW:
            if (cnt_r == 3'(`FWSP_WP_CYC - 1))                      // R16
            begin
               pins_nxt.we_n = 1'b1;
               cnt_nxt       = 3'h0;
               st_nxt        = FWSP_S_WHIGH;
            end
         FWSP_S_WHIGH:
            if (cnt_r == 3'(`FWSP_WPH_CYC - 1))                     // R16
            begin
               pins_nxt.ce_n  = 1'b1;
               pins_nxt.dq_oe = 1'b0;
               st_nxt         = FWSP_S_NEXT;
            end
         FWSP_S_RLOW:
            if (cnt_r == 3'(`FWSP_RC_CYC - 1))
            begin
               rdata_nxt     = I_FL_DQ;
               pins_nxt.oe_n = 1'b1;
               pins_nxt.ce_n = 1'b1;
               cnt_nxt       = 3'h0;
               st_nxt        = FWSP_S_RHOLD;
            end
         FWSP_S_RHOLD:
            if (cnt_r == 3'(`FWSP_OEH_CYC - 1))
               st_nxt = FWSP_S_NEXT;
         FWSP_S_NEXT:
         begin
            cnt_nxt = 3'h0;
            st_nxt  = FWSP_S_IDLE;
            if (op_r == `FWSP_OP_POLL)
            begin
               st_nxt = FWSP_S_RLOW;
               if (!step_r[0])
               begin
                  tog_nxt  = rdata_r[`FWSP_B_TOG1];                 // R20
                  step_nxt = step_r + 2'h1;
               end
               else if (rdata_r[`FWSP_B_TOG1] == tog_r)
                  st_nxt = FWSP_S_IDLE;                             // R20
               else if (step_r == 2'h3)
               begin
                  stat_nxt.fail = 1'b1;                             // R1 R7
                  st_nxt        = FWSP_S_IDLE;
               end
               else
                  step_nxt = rdata_r[`FWSP_B_TMO] ? 2'h2 : 2'h0;    // R2 R5
               if (st_nxt == FWSP_S_RLOW)
                  pins_nxt = fwsp_launch(1'b0, addr_r, wdata_r);    // R8
            end
            else if ((op_r == `FWSP_OP_SECT) && (step_r != 2'h2))
            begin
               step_nxt = step_r + 2'h1;
               pins_nxt = fwsp_launch(fwsp_is_wr(op_r, step_nxt), addr_r, wdata_r);
               st_nxt   = fwsp_is_wr(op_r, step_nxt) ? FWSP_S_WSET : FWSP_S_RLOW;
            end
            else if (op_r == `FWSP_OP_SECT)
               stat_nxt.reject = rdata_r[`FWSP_B_WIN];              // R13 R11
            else if (op_r == `FWSP_OP_RESET)
               stat_nxt.fail = 1'b0;                                // R3 R21
            if (st_nxt == FWSP_S_IDLE)
            begin
               stat_nxt.busy = 1'b0;
               stat_nxt.done = 1'b1;
            end
         end
         default:
         begin
            pins_nxt = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, default: '0};
            st_nxt   = FWSP_S_IDLE;
         end
      endcase
   end

   always_ff @(posedge I_REF_CLK)
   begin
      if (!I_RESETN)
      begin
         st_r    <= FWSP_S_IDLE;
         pins_r  <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, default: '0};
         cnt_r   <= 3'h0;
         step_r  <= 2'h0;
         op_r    <= 3'h0;
         rdata_r <= '0;
         tog_r   <= 1'b0;
         stat_r  <= '0;
      end
      else if (I_CE)
      begin
         st_r    <= st_nxt;
         pins_r  <= pins_nxt;
         cnt_r   <= cnt_nxt;
         step_r  <= step_nxt;
         op_r    <= op_nxt;
         rdata_r <= rdata_nxt;
         tog_r   <= tog_nxt;
         stat_r  <= stat_nxt;
      end
   end

   // ==========================================================================
   // Outputs
   assign O_WB_ACK = ack_r;
   assign O_WB_DAT = dat_r;
   assign O_FLASH  = pins_r;
endmodule : fwsp_ctrl

// file: rtl/fwsp_defs.svh
// Constants of the flash write-status controller
`ifndef FWSP_DEFS_SVH
`define FWSP_DEFS_SVH

// ==========================================================================
// Widths
`define FWSP_AW           19
`define FWSP_DW           16
`define FWSP_WB_AW        8

// ==========================================================================
// Timing
`define FWSP_CLK_NS       20
`define FWSP_T_RC_NS      70
`define FWSP_T_WP_NS      35
`define FWSP_T_WPH_NS     30
`define FWSP_T_OEH_NS     10
`define FWSP_CYC(ns)      (((ns) + `FWSP_CLK_NS - 1) / `FWSP_CLK_NS)
`define FWSP_RC_CYC       `FWSP_CYC(`FWSP_T_RC_NS)
`define FWSP_WP_CYC       `FWSP_CYC(`FWSP_T_WP_NS)
`define FWSP_WPH_CYC      `FWSP_CYC(`FWSP_T_WPH_NS)
`define FWSP_OEH_CYC      `FWSP_CYC(`FWSP_T_OEH_NS)

// ==========================================================================
// Register offsets
`define FWSP_REG_CMD      8'h00
`define FWSP_REG_ADDR     8'h04
`define FWSP_REG_WDATA    8'h08
`define FWSP_REG_RDATA    8'h0c
`define FWSP_REG_STATUS   8'h10

// ==========================================================================
// Command codes
`define FWSP_OP_WRITE     3'h1
`define FWSP_OP_READ      3'h2
`define FWSP_OP_POLL      3'h3
`define FWSP_OP_RESET     3'h4
`define FWSP_OP_SECT      3'h5
`define FWSP_FL_RESET_CMD 16'h00f0

// ==========================================================================
// Flash status bit positions
`define FWSP_B_POLL       7
`define FWSP_B_TOG1       6
`define FWSP_B_TMO        5
`define FWSP_B_WIN        3
`define FWSP_B_TOG2       2

`endif

// file: rtl/fwsp_pkg.sv
// Types of the flash write-status controller
`include "fwsp_defs.svh"

package fwsp_pkg;

   typedef enum logic [6:0]
   {
      FWSP_S_IDLE  = 7'h01,
      FWSP_S_WSET  = 7'h02,
      FWSP_S_WLOW  = 7'h04,
      FWSP_S_WHIGH = 7'h08,
      FWSP_S_RLOW  = 7'h10,
      FWSP_S_RHOLD = 7'h20,
      FWSP_S_NEXT  = 7'h40
   } fwsp_state_t;

   typedef struct packed
   {
      logic                 ce_n;
      logic                 we_n;
      logic                 oe_n;
      logic [`FWSP_AW-1:0]  addr;
      logic [`FWSP_DW-1:0]  dq;
      logic                 dq_oe;
   } fwsp_pins_t;

   typedef struct packed
   {
      logic ready;
      logic reject;
      logic fail;
      logic done;
      logic busy;
   } fwsp_stat_t;

endpackage : fwsp_pkg

// file: verification/fwsp_ctrl_asserts.sv
// Port checks of the flash write-status controller
`timescale 1ns/1ns
`include "fwsp_defs.svh"
module fwsp_ctrl_asserts
(
   input wire logic                 I_REF_CLK,
   input wire logic                 I_RESETN,
   input wire logic                 I_WB_CYC,
   input wire logic                 I_WB_STB,
   input wire logic                 O_WB_ACK,
   input wire fwsp_pkg::fwsp_pins_t O_FLASH
);
   import fwsp_pkg::*;
   // ==========================================
   // Bus answer and strobe shapes
   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (!I_RESETN);
   sequence s_we_low; !O_FLASH.we_n [*2]; endsequence
   sequence s_ce_low; !O_FLASH.ce_n [*4]; endsequence
   chk_ack_answer: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
      else $error("request not acked next cycle");
   chk_ack_single: assert property (O_WB_ACK |=> !O_WB_ACK)
      else $error("ack longer than one cycle");
   chk_write_gate: assert property (!O_FLASH.we_n |-> !O_FLASH.ce_n && O_FLASH.oe_n)
      else $error("write strobe outside select");
   chk_read_gate: assert property (!O_FLASH.oe_n |-> !O_FLASH.ce_n && O_FLASH.we_n)
      else $error("output strobe during write");
   chk_we_pulse: assert property ($fell(O_FLASH.we_n) |-> s_we_low)
      else $error("short write pulse");
   chk_ce_pulse: assert property ($fell(O_FLASH.ce_n) |-> s_ce_low)
      else $error("short select pulse");
   chk_dq_drive: assert property (!O_FLASH.we_n |-> O_FLASH.dq_oe && $stable(O_FLASH.dq))
      else $error("write data not held");
   chk_addr_hold: assert property (!O_FLASH.ce_n && !$past(O_FLASH.ce_n)
      |-> $stable(O_FLASH.addr))
      else $error("address moved in access");
endmodule : fwsp_ctrl_asserts
bind fwsp_ctrl fwsp_ctrl_asserts u_fwsp_ctrl_asserts
(
   .I_REF_CLK(I_REF_CLK), .I_RESETN(I_RESETN), .I_WB_CYC(I_WB_CYC),
   .I_WB_STB(I_WB_STB), .O_WB_ACK(O_WB_ACK), .O_FLASH(O_FLASH)
);

// file: verification/fwsp_flash_model.sv
// Behavioural flash device facing the controller
`timescale 1ns/1ns
`include "fwsp_defs.svh"
module fwsp_flash_model
(
   input  wire logic                 i_clk,
   input  wire fwsp_pkg::fwsp_pins_t i_pins,
   output logic [`FWSP_DW-1:0]       o_dq,
   output logic                      o_ready_busy_n
);
   import fwsp_pkg::*;
   // ==========================================
   // Embedded operation state
   logic [15:0] mem_r = 16'h0, last_r = 16'h0, sts;
   logic        busy_r = 1'b0;
   logic        tmo_r = 1'b0, ers_r = 1'b0, bad_r = 1'b0;
   logic        tog_r = 1'b0, we_d = 1'b1, oe_d = 1'b1;
   int          cnt_r = 0;
   wire logic   wr = !we_d && i_pins.we_n && !i_pins.ce_n && i_pins.oe_n;
   wire logic   ecmd = i_pins.dq == 16'h0030;
   always @(posedge i_clk)
   begin
      we_d <= i_pins.we_n;
      oe_d <= i_pins.oe_n;
      if (busy_r && !tmo_r)
         cnt_r <= cnt_r + 1;
      if (busy_r && !tmo_r && bad_r && cnt_r == 20)
         tmo_r <= 1'b1;
      if (busy_r && !tmo_r && cnt_r == (ers_r ? 400 : 60))
         busy_r <= 1'b0;
      if (oe_d && !i_pins.oe_n && !i_pins.ce_n && busy_r)
         tog_r <= ~tog_r;
      if (!i_pins.ce_n && !i_pins.oe_n)
         last_r <= o_dq;
      if (wr && i_pins.dq == `FWSP_FL_RESET_CMD)
      begin
         busy_r <= 1'b0;
         tmo_r <= 1'b0;
      end
      else if (wr && !busy_r)
      begin
         busy_r <= 1'b1;
         cnt_r <= 0;
         ers_r <= ecmd;
         bad_r <= &i_pins.addr;
         if (!ecmd)
            mem_r <= i_pins.dq;
      end
      else if (wr && ers_r && cnt_r < 40 && ecmd)
         cnt_r <= 0;
   end
   always_comb
   begin
      sts = 16'h0;
      sts[7] = ers_r ? 1'b0 : ~mem_r[7];
      sts[6] = tog_r;
      sts[5] = tmo_r;
      sts[3] = ers_r && cnt_r >= 40;
      sts[2] = ers_r && tog_r;
      if (i_pins.ce_n || i_pins.oe_n)
         o_dq = ~last_r;
      else
         o_dq = busy_r ? sts : mem_r;
   end
   assign o_ready_busy_n = ~busy_r;
endmodule : fwsp_flash_model

// file: verification/tb_fwsp_ctrl.sv
// Self-checking bench for the flash write-status controller
`timescale 1ns/1ns
`include "fwsp_defs.svh"
module tb_fwsp_ctrl;
   import fwsp_pkg::*;
   // ==========================================
   // Clock, bus and data wire
   logic        clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, rd;
   logic        ack, rb_n;
   logic [15:0] mdq;
   fwsp_pins_t  pins;
   int          fail_count = 0, total_checks = 0, cycles = 0;
   wire logic [15:0] fl_dq = pins.dq_oe ? pins.dq : mdq;
   fwsp_ctrl u_fwsp_ctrl
   (
      .I_REF_CLK(clk), .I_RESETN(rst_n), .I_CE(1'b1), .I_WB_CYC(cyc),
      .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_DAT(wdat),
      .I_WB_SEL(4'hf), .O_WB_DAT(rdat), .O_WB_ACK(ack), .O_FLASH(pins),
      .I_FL_DQ(fl_dq), .I_READY_BUSY_N(rb_n)
   );
   fwsp_flash_model u_fwsp_flash_model
   (
      .i_clk(clk), .i_pins(pins), .o_dq(mdq), .o_ready_busy_n(rb_n)
   );
   initial forever #10 clk = ~clk;
   // ==========================================
   // Tasks
   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : results
   task automatic check(input string n, input logic [31:0] seen, exp);
      total_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", n, exp, seen);
      end
   endtask : check
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clk); while (ack !== 1'b1);
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk);
   endtask : wb
   task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] m, e);
      wb(1'b0, a, 32'h0);
      check(n, rd & m, e);
   endtask : rdchk
   task automatic op(input logic [2:0] c);
      wb(1'b1, `FWSP_REG_CMD, {29'h0, c});
      do wb(1'b0, `FWSP_REG_STATUS, 32'h0); while (rd[0] !== 1'b0);
   endtask : op
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         fail_count++;
         results();
      end
   end
   // ==========================================
   // Scenarios
   initial
   begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rdchk("status idle", `FWSP_REG_STATUS, 32'h1f, 32'h10);
      rdchk("unmapped", 8'h20, 32'hffffffff, 32'h0);
      wb(1'b1, `FWSP_REG_ADDR, 32'h100);
      wb(1'b1, `FWSP_REG_WDATA, 32'h1234);
      op(`FWSP_OP_WRITE);
      op(`FWSP_OP_READ);
      rdchk("pgm bits", `FWSP_REG_RDATA, 32'ha4, 32'h80);
      rdchk("pgm busy", `FWSP_REG_STATUS, 32'h10, 32'h0);
      op(`FWSP_OP_POLL);
      rdchk("pgm poll", `FWSP_REG_STATUS, 32'h1f, 32'h12);
      rdchk("cmd code", `FWSP_REG_CMD, 32'h7, 32'h3);
      op(`FWSP_OP_READ);
      rdchk("pgm data", `FWSP_REG_RDATA, 32'hffff, 32'h1234);
      wb(1'b1, `FWSP_REG_ADDR, 32'h7ffff);
      op(`FWSP_OP_WRITE);
      op(`FWSP_OP_POLL);
      rdchk("tmo fail", `FWSP_REG_STATUS, 32'h1f, 32'h06);
      op(`FWSP_OP_READ);
      rdchk("tmo bit", `FWSP_REG_RDATA, 32'h20, 32'h20);
      wb(1'b1, `FWSP_REG_WDATA, 32'h0055);
      op(`FWSP_OP_WRITE);
      op(`FWSP_OP_RESET);
      rdchk("reset", `FWSP_REG_STATUS, 32'h1f, 32'h12);
      op(`FWSP_OP_READ);
      rdchk("tmo ignored", `FWSP_REG_RDATA, 32'hffff, 32'h1234);
      wb(1'b1, `FWSP_REG_ADDR, 32'h100);
      wb(1'b1, `FWSP_REG_WDATA, 32'h0030);
      op(`FWSP_OP_WRITE);
      op(`FWSP_OP_SECT);
      rdchk("win open", `FWSP_REG_STATUS, 32'h08, 32'h0);
      do
      begin
         op(`FWSP_OP_READ);
         wb(1'b0, `FWSP_REG_RDATA, 32'h0);
      end
      while (rd[3] !== 1'b1);
      check("erase bits", rd & 32'ha0, 32'h0);
      op(`FWSP_OP_SECT);
      rdchk("win shut", `FWSP_REG_STATUS, 32'h08, 32'h08);
      op(`FWSP_OP_POLL);
      rdchk("erase done", `FWSP_REG_STATUS, 32'h1f, 32'h1a);
      results();
   end
endmodule : tb_fwsp_ctrl
